// >>> testbench/pch_host_model.sv
`timescale 1ns/1ps
module pch_host_model (
  // clock
  input  wire logic                  clk_sys,
  // configuration access
  output pch_pkg::pch_cfg_req_t      cfgReq,
  input  wire pch_pkg::pch_cfg_rsp_t cfgRsp
);
  import pch_pkg::*;

  logic        lastOk;
  logic [31:0] lastRd;

  initial cfgReq = '0;

  //////////////////////////////////////////////////////////////////////////
  // one dword access; released lines carry the inverse, never stale data
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_sys);
    #1;
    cfgReq = '{valid: 1'b1, write: wr, addr: a, byteEn: be, wdata: d};
    @(posedge clk_sys);
    #1;
    lastOk = cfgRsp.valid;
    lastRd = cfgRsp.rdata;
    cfgReq = '{valid: 1'b0, write: ~wr, addr: ~a, byteEn: ~be, wdata: ~d};
  endtask
endmodule // pch_host_model

// >>> testbench/tb_pci_config_header.sv
`timescale 1ns/1ps
module tb_pci_config_header;
  import pch_pkg::*;

  localparam int unsigned B0  = 7;
  localparam int unsigned B1  = 6;
  localparam logic [15:0] MID = 16'h3c3c; // arbitrary value
  localparam logic [15:0] PID = 16'hc3c3; // arbitrary value
  localparam logic [7:0]  REV = 8'h2e;    // arbitrary value

  logic         clk_sys;
  logic         srst;
  pch_cfg_req_t cfgReq;
  pch_cfg_rsp_t cfgRsp;
  pch_space_t   spaceReq;
  pch_evt_t     busEvt;
  logic         bar0Hit, bar1Hit, perrDrive, serrDrive;
  pch_cmd_t     cmdCtl;
  int           errors;
  int           check_count;
  integer       seed;
  logic [31:0]  cmdM, stM, miscM, irqM, bar0M, bar1M, romM, rnd;

  pch_config_header #(
    .MAKER_ID(MID), .PART_ID(PID), .REVISION(REV), .BAR0_LOG2(B0),
    .BAR1_LOG2(B1), .BAR1_IS_IO(1'b1), .STEP_MODE(PCH_STEP_NEVER)
  ) dut (
    .clk_sys(clk_sys), .srst(srst), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
    .spaceReq(spaceReq), .bar0Hit(bar0Hit), .bar1Hit(bar1Hit),
    .busEvt(busEvt), .perrDrive(perrDrive), .serrDrive(serrDrive),
    .cmdCtl(cmdCtl)
  );

  pch_host_model host (.clk_sys(clk_sys), .cfgReq(cfgReq), .cfgRsp(cfgRsp));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference model
  function automatic logic [31:0] lanes(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] expRd(input logic [7:0] a);
    case (a & 8'hfc)
      8'h00: return {PID, MID};
      8'h04: return {stM[15:0], cmdM[15:0]};
      8'h08: return {24'h008000, REV};
      8'h0c: return miscM;
      8'h10: return bar0M;
      8'h14: return bar1M | 32'h1;
      8'h30: return romM;
      8'h3c: return irqM;
      default: return 32'h0;
    endcase
  endfunction

  function automatic void mdlWr(input logic [7:0] a, input logic [3:0] be,
                                input logic [31:0] d);
    logic [31:0] m;
    logic [31:0] v;
    m = lanes(be);
    v = d & m;
    case (a & 8'hfc)
      8'h04: begin
        cmdM = ((cmdM & ~m) | v) & 32'h37f;
        stM  = stM & ~(v >> 16);
      end
      8'h0c: miscM = ((miscM & ~m) | v) & 32'hffff;
      8'h10: bar0M = ((bar0M & ~m) | v) & ~((32'h1 << B0) - 1);
      8'h14: bar1M = ((bar1M & ~m) | v) & ~((32'h1 << B1) - 1);
      8'h30: romM = (romM & ~m) | v;
      8'h3c: irqM = ((irqM & ~m) | v) & 32'hff;
      default: ;
    endcase
  endfunction

  function automatic void mdlRst();
    cmdM  = 32'h0;
    stM   = 32'h0;
    miscM = 32'h0;
    irqM  = 32'hff;
    bar0M = 32'h0;
    bar1M = 32'h0;
    romM  = 32'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // checks and transfers
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a);
    host.access(1'b0, a, 4'hf, 32'h0);
    check({31'h0, host.lastOk}, 32'h1, "no read answer");
    check(host.lastRd, expRd(a), "read data");
    check({22'h0, cmdCtl}, cmdM & 32'h3ff, "command in use");
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    host.access(1'b1, a, be, d);
    mdlWr(a, be, d);
    check({31'h0, host.lastOk}, 32'h1, "no write answer");
    check(host.lastRd, 32'h0, "write answer data");
  endtask

  task automatic probe(input logic io, input logic [31:0] a);
    logic h0;
    logic h1;
    h0 = !io && cmdM[1] && (a[31:B0] == bar0M[31:B0]);
    h1 = io && cmdM[0] && (a[31:B1] == bar1M[31:B1]);
    @(posedge clk_sys);
    #1;
    spaceReq = '{valid: 1'b1, isIo: io, addr: a};
    @(posedge clk_sys);
    #1;
    spaceReq = '{valid: 1'b0, isIo: ~io, addr: ~a};
    check({bar1Hit, bar0Hit}, {h1, h0}, "space hit");
  endtask

  task automatic evt(input logic pe, input logic ape, input logic ta);
    logic ep;
    logic es;
    ep = pe && cmdM[6];
    es = ape && cmdM[8] && cmdM[6];
    @(posedge clk_sys);
    #1;
    busEvt = '{parityErr: pe, addrParityErr: ape, targetAbort: ta};
    @(posedge clk_sys);
    #1;
    busEvt = '0;
    check({serrDrive, perrDrive}, {es, ep}, "error drive");
    stM = stM | {pe, es, 2'b0, ta, 11'h0};
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    mdlRst();
  endtask

  initial begin
    #2000000;
    errors++;
    $display("wrong value at %0t: run timed out", $time);
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    srst = 1'b1;
    spaceReq = '0;
    busEvt = '0;
    errors = 0;
    check_count = 0;
    seed = 32'h2d5039f3;
    do_reset();
    check({22'h0, cmdCtl}, 32'h0, "command reset");
    foreach (rnd[i]) if (i < 9) rd(i[7:0] << 2);
    rd(8'h02);
    rd(8'h3c);
    rd(8'h40);
    $display("test reset_values done");
    foreach (rnd[i]) begin
      wr(8'h04 + (i[7:0] << 3), 4'hf, $random(seed));
    end
    wr(8'h00, 4'hf, 32'hffffffff);
    wr(8'h08, 4'hf, 32'hffffffff);
    wr(8'h0c, 4'hf, $random(seed));
    wr(8'h3c, 4'hf, $random(seed));
    wr(8'h10, 4'hf, 32'hffffffff);
    rd(8'h10);
    wr(8'h14, 4'hf, 32'hffffffff);
    rd(8'h14);
    wr(8'h30, 4'hf, $random(seed));
    for (int a = 0; a < 256; a += 12) rd(a[7:0]);
    $display("test header_map done");
    wr(8'h04, 4'h3, 32'hffff);
    rd(8'h04);
    repeat (12) begin
      rnd = $random(seed);
      wr(8'h04, rnd[3:0] | 4'h1, $random(seed));
      rd(8'h04);
    end
    $display("test command_bits done");
    wr(8'h10, 4'hf, 32'h12345600);
    wr(8'h14, 4'hf, 32'h0000a5c0);
    for (int c = 0; c < 4; c++) begin
      wr(8'h04, 4'h3, 32'(c));
      rd(8'h10);
      probe(1'b0, 32'h12345610);
      probe(1'b0, 32'h12345680);
      probe(1'b1, 32'h0000a5c4);
      probe(1'b1, 32'h0000a600);
      probe(1'b1, 32'h12345610);
    end
    $display("test space_decode done");
    wr(8'h04, 4'h3, 32'h0);
    evt(1'b1, 1'b0, 1'b0);
    rd(8'h04);
    wr(8'h04, 4'h3, 32'h40);
    evt(1'b1, 1'b0, 1'b0);
    evt(1'b0, 1'b1, 1'b0);
    wr(8'h04, 4'h3, 32'h140);
    evt(1'b0, 1'b1, 1'b0);
    evt(1'b0, 1'b0, 1'b1);
    rd(8'h04);
    wr(8'h04, 4'h3, 32'hc8000140);
    rd(8'h04);
    wr(8'h04, 4'hc, 32'h40000000);
    rd(8'h04);
    wr(8'h04, 4'hc, 32'hffff0000);
    rd(8'h04);
    $display("test status_events done");
    do_reset();
    check({22'h0, cmdCtl}, 32'h0, "command reset");
    rd(8'h04);
    rd(8'h0c);
    rd(8'h3c);
    rd(8'h10);
    rd(8'h14);
    rd(8'h30);
    $display("test second_reset done");
    close_out();
  end
endmodule // tb_pci_config_header

// >>> verilog/pch_config_header.sv
`timescale 1ns/1ps
//Contract
// - 256-byte configuration space, header plus device area
// - first 64 bytes follow standard header layout
// - configuration accesses answered at any time
// - identifiers, command and status always implemented
// - supported functions use standard location, meaning
// - reads return values actually in use
// - five identification fields are read-only
// - header type reports layout 00h, bit 7
// - class code bytes at 0Bh, 0Ah, 09h
// - zero command disconnects all but configuration
// - command bit 0 enables I/O, resets 0
// - command bit 1 enables memory, resets 0
// - command bit 2 enables mastering, resets 0
// - command bit 3 monitors special cycles
// - command bit 4 permits write-and-invalidate
// - command bit 5 enables palette snooping
// - command bit 6 parity response, resets 0
// - command bit 7 stepping per capability
// - bit 8 system error; address parity needs 6,8
// - bit 9 fast back-to-back, software sets
// - status bits clear on written one
// - base register bit 0 shows space type
// - sizing returns zeros below decode size
// - base at 14h maps board registers, no irq
module pch_config_header
  import pch_pkg::*;
#(
  parameter logic [15:0] MAKER_ID     = 16'h5a5a, // arbitrary value
  parameter logic [15:0] PART_ID      = 16'ha5a5, // arbitrary value
  parameter logic [7:0]  REVISION     = 8'h01,    // arbitrary value
  parameter int unsigned BAR0_LOG2    = 7,
  parameter int unsigned BAR1_LOG2    = 6,
  parameter logic        BAR1_IS_IO   = 1'b1,
  parameter pch_step_t   STEP_MODE    = PCH_STEP_NEVER
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               srst,
  // configuration access
  input  wire pch_pkg::pch_cfg_req_t cfgReq,
  output pch_pkg::pch_cfg_rsp_t   cfgRsp,
  // memory and I/O space decode
  input  wire pch_pkg::pch_space_t spaceReq,
  output logic                    bar0Hit,
  output logic                    bar1Hit,
  // bus events and error drivers
  input  wire pch_pkg::pch_evt_t  busEvt,
  output logic                    perrDrive,
  output logic                    serrDrive,
  // command state in use
  output pch_pkg::pch_cmd_t       cmdCtl
);
  import pch_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic hitWord(input logic [7:0] a,
                                   input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  localparam logic [31:0] BAR0_MASK = ~((32'h1 << BAR0_LOG2) - 32'h1);
  localparam logic [31:0] BAR1_MASK = ~((32'h1 << BAR1_LOG2) - 32'h1);
  localparam logic [3:0]  BAR0_TYPE = 4'h0;
  localparam logic [3:0]  BAR1_TYPE = BAR1_IS_IO ? 4'h1 : 4'h0;
  localparam logic        STEP_RST  = (STEP_MODE != PCH_STEP_NEVER);

  ////////////////////////////////////////////////////////////////////////////
  // state
  pch_cmd_t     cmd_r;
  logic [15:0]  status_r;
  logic [31:0]  bar0_r;
  logic [31:0]  bar1_r;
  logic [31:0]  rom_r;
  logic [7:0]   cache_r;
  logic [7:0]   latency_r;
  logic [7:0]   irqLine_r;
  pch_cfg_rsp_t rsp_r;
  logic         bar0Hit_r;
  logic         bar1Hit_r;
  logic         perr_r;
  logic         serr_r;

  logic         wrEn;
  logic         inHeader;
  logic         serrEvt;
  logic [31:0]  cmdWord;
  logic [31:0]  rdWord;

  assign wrEn     = cfgReq.valid && cfgReq.write;
  assign inHeader = cfgReq.addr < 8'(HDR_BYTES);
  assign serrEvt  = busEvt.addrParityErr && cmd_r.serrEn
                    && cmd_r.parityEn;
  assign cmdWord  = mergeBytes({22'h0, cmd_r}, cfgReq.wdata,
                               cfgReq.byteEn);

  ////////////////////////////////////////////////////////////////////////////
  // command register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_r        <= CMD_RST;
      cmd_r.stepEn <= STEP_RST;
    end else if (wrEn && hitWord(cfgReq.addr, OFF_CMDSTAT)) begin
      cmd_r <= pch_cmd_t'(cmdWord[9:0]);
      if (STEP_MODE != PCH_STEP_OPTIONAL) begin
        cmd_r.stepEn <= STEP_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: events set, written ones clear, set wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_r <= 16'h0000;
    end else begin
      for (int b = 0; b < 16; b++) begin
        if (wrEn && hitWord(cfgReq.addr, OFF_CMDSTAT)
            && cfgReq.byteEn[2 + b/8] && cfgReq.wdata[16 + b]) begin
          status_r[b] <= 1'b0;
        end
      end
      if (busEvt.parityErr) begin
        status_r[ST_PAR_DET] <= 1'b1;
      end
      if (serrEvt) begin
        status_r[ST_SERR_SIG] <= 1'b1;
      end
      if (busEvt.targetAbort) begin
        status_r[ST_TABORT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // base address, expansion rom and writable misc bytes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bar0_r <= 32'h0000_0000;
      bar1_r <= 32'h0000_0000;
      rom_r  <= 32'h0000_0000;
    end else if (wrEn) begin
      if (hitWord(cfgReq.addr, OFF_BAR0)) begin
        bar0_r <= mergeBytes(bar0_r, cfgReq.wdata, cfgReq.byteEn)
                  & BAR0_MASK;
      end
      if (hitWord(cfgReq.addr, OFF_BAR1)) begin
        bar1_r <= mergeBytes(bar1_r, cfgReq.wdata, cfgReq.byteEn)
                  & BAR1_MASK;
      end
      if (hitWord(cfgReq.addr, OFF_ROM)) begin
        rom_r <= mergeBytes(rom_r, cfgReq.wdata, cfgReq.byteEn);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cache_r   <= CACHE_RST;
      latency_r <= LAT_RST;
      irqLine_r <= IRQ_LINE_RST;
    end else if (wrEn) begin
      if (hitWord(cfgReq.addr, OFF_MISC) && cfgReq.byteEn[0]) begin
        cache_r <= cfgReq.wdata[7:0];
      end
      if (hitWord(cfgReq.addr, OFF_MISC) && cfgReq.byteEn[1]) begin
        latency_r <= cfgReq.wdata[15:8];
      end
      if (hitWord(cfgReq.addr, OFF_IRQ) && cfgReq.byteEn[0]) begin
        irqLine_r <= cfgReq.wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux: live values, identifiers constant
  always_comb begin
    rdWord = 32'h0000_0000;
    if (inHeader) begin
      case (cfgReq.addr[5:2])
        OFF_IDENT[5:2]:   rdWord = {PART_ID, MAKER_ID};
        OFF_CMDSTAT[5:2]: rdWord = {status_r[15:11], DEVSEL_TIMING,
                                    1'b0, FAST_B2B_CAP, 7'h00,
                                    6'h00, cmd_r};
        OFF_REVCLS[5:2]:  rdWord = {CLASS_VAL, REVISION};
        OFF_MISC[5:2]:    rdWord = {BUILTIN_SELFTEST_VAL, HDR_TYPE_VAL,
                                    latency_r, cache_r};
        OFF_BAR0[5:2]:    rdWord = {bar0_r[31:BAR_TYPE_BITS],
                                    BAR0_TYPE};
        OFF_BAR1[5:2]:    rdWord = {bar1_r[31:BAR_TYPE_BITS],
                                    BAR1_TYPE};
        OFF_ROM[5:2]:     rdWord = rom_r;
        OFF_IRQ[5:2]:     rdWord = {BUS_LATENCY_MAXIMUM_VAL, MIN_GNT_VAL,
                                    IRQ_PIN_VAL, irqLine_r};
        default:          rdWord = 32'h0000_0000;
      endcase
    end
  end

  // every access is answered one cycle later, reads and writes alike
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= cfgReq.valid;
      rsp_r.rdata <= (cfgReq.valid && !cfgReq.write) ? rdWord
                                                     : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // space decode and error drivers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bar0Hit_r <= 1'b0;
      bar1Hit_r <= 1'b0;
    end else begin
      bar0Hit_r <= spaceReq.valid && !spaceReq.isIo && cmd_r.memEn
                   && ((spaceReq.addr & BAR0_MASK) == bar0_r);
      bar1Hit_r <= spaceReq.valid && (spaceReq.isIo == BAR1_IS_IO)
                   && (BAR1_IS_IO ? cmd_r.ioEn : cmd_r.memEn)
                   && ((spaceReq.addr & BAR1_MASK) == bar1_r);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      perr_r <= 1'b0;
      serr_r <= 1'b0;
    end else begin
      perr_r <= busEvt.parityErr && cmd_r.parityEn;
      serr_r <= serrEvt;
    end
  end

  assign cfgRsp    = rsp_r;
  assign bar0Hit   = bar0Hit_r;
  assign bar1Hit   = bar1Hit_r;
  assign perrDrive = perr_r;
  assign serrDrive = serr_r;
  assign cmdCtl    = cmd_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_answer;
    @(posedge clk_sys) disable iff (srst)
      cfgReq.valid |=> cfgRsp.valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("config access not answered");

  property p_ident;
    @(posedge clk_sys) disable iff (srst)
      (cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == 6'h00)
      |=> cfgRsp.rdata == {PART_ID, MAKER_ID};
  endproperty
  a_ident: assert property (p_ident)
    else $error("identifier read wrong");

  property p_class;
    @(posedge clk_sys) disable iff (srst)
      (cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == 6'h02)
      |=> cfgRsp.rdata[31:8] == CLASS_VAL;
  endproperty
  a_class: assert property (p_class)
    else $error("class code read wrong");

  property p_hdrType;
    @(posedge clk_sys) disable iff (srst)
      (cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == 6'h03)
      |=> cfgRsp.rdata[23:16] == HDR_TYPE_VAL;
  endproperty
  a_hdrType: assert property (p_hdrType)
    else $error("header type read wrong");

  property p_disconnect;
    @(posedge clk_sys) disable iff (srst)
      (!cmd_r.memEn && !cmd_r.ioEn) |=> !bar0Hit && !bar1Hit;
  endproperty
  a_disconnect: assert property (p_disconnect)
    else $error("space claimed while disabled");

  property p_resetCmd;
    @(posedge clk_sys)
      srst |=> (cmdCtl.ioEn == 1'b0 && cmdCtl.memEn == 1'b0
                && cmdCtl.parityEn == 1'b0 && cmdCtl.serrEn == 1'b0
                && cmdCtl.stepEn == STEP_RST);
  endproperty
  a_resetCmd: assert property (p_resetCmd)
    else $error("command reset value wrong");

  property p_serr;
    @(posedge clk_sys) disable iff (srst)
      serrDrive |-> $past(cmd_r.serrEn) && $past(cmd_r.parityEn)
                    && $past(busEvt.addrParityErr);
  endproperty
  a_serr: assert property (p_serr)
    else $error("system error without both enables");

  property p_statusSet;
    @(posedge clk_sys) disable iff (srst)
      busEvt.parityErr |=> status_r[ST_PAR_DET] ##1
      (status_r[ST_PAR_DET] || $past(wrEn));
  endproperty
  a_statusSet: assert property (p_statusSet)
    else $error("parity event lost");

  property p_barLow;
    @(posedge clk_sys) disable iff (srst)
      (cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == 6'h04)
      |=> cfgRsp.rdata[BAR0_LOG2-1:0] == '0;
  endproperty
  a_barLow: assert property (p_barLow)
    else $error("base register low bits not zero");

  property p_barType;
    @(posedge clk_sys) disable iff (srst)
      (cfgReq.valid && !cfgReq.write && cfgReq.addr[7:2] == 6'h05)
      |=> cfgRsp.rdata[0] == BAR1_IS_IO;
  endproperty
  a_barType: assert property (p_barType)
    else $error("base register space type wrong");

  property p_unmapped;
    @(posedge clk_sys) disable iff (srst)
      (cfgReq.valid && !cfgReq.write && cfgReq.addr >= 8'h40)
      |=> cfgRsp.rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped location not zero");

endmodule // pch_config_header

// >>> verilog/pch_pkg.sv
package pch_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // space sizes and header offsets (byte addresses)
  localparam int unsigned CFG_BYTES   = 256;
  localparam int unsigned HDR_BYTES   = 64;
  localparam logic [7:0]  OFF_IDENT   = 8'h00;
  localparam logic [7:0]  OFF_CMDSTAT = 8'h04;
  localparam logic [7:0]  OFF_REVCLS  = 8'h08;
  localparam logic [7:0]  OFF_CLSBASE = 8'h0b;
  localparam logic [7:0]  OFF_CLSSUB  = 8'h0a;
  localparam logic [7:0]  OFF_CLSPROG = 8'h09;
  localparam logic [7:0]  OFF_MISC    = 8'h0c;
  localparam logic [7:0]  OFF_BAR0    = 8'h10;
  localparam logic [7:0]  OFF_BAR1    = 8'h14;
  localparam logic [7:0]  OFF_ROM     = 8'h30;
  localparam logic [7:0]  OFF_IRQ     = 8'h3c;

  ////////////////////////////////////////////////////////////////////////////
  // fixed and reset values
  localparam logic [23:0] CLASS_VAL      = 24'h008000;
  localparam logic [7:0]  HDR_TYPE_VAL   = 8'h00;
  localparam logic [7:0]  BUILTIN_SELFTEST_VAL       = 8'h00;
  localparam logic [7:0]  IRQ_PIN_VAL    = 8'h00;
  localparam logic [7:0]  MIN_GNT_VAL    = 8'h00;
  localparam logic [7:0]  BUS_LATENCY_MAXIMUM_VAL    = 8'h00;
  localparam logic [7:0]  IRQ_LINE_RST   = 8'hff;
  localparam logic [7:0]  CACHE_RST      = 8'h00;
  localparam logic [7:0]  LAT_RST        = 8'h00;
  localparam logic [1:0]  DEVSEL_TIMING  = 2'h0;
  localparam logic        FAST_B2B_CAP   = 1'b0;
  localparam int unsigned BAR_TYPE_BITS  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // status bit positions
  localparam int unsigned ST_PAR_DET  = 15;
  localparam int unsigned ST_SERR_SIG = 14;
  localparam int unsigned ST_TABORT   = 11;

  ////////////////////////////////////////////////////////////////////////////
  // stepping modes
  typedef enum logic [1:0] {
    PCH_STEP_NEVER,
    PCH_STEP_ALWAYS,
    PCH_STEP_OPTIONAL
  } pch_step_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic fastB2bEn;
    logic serrEn;
    logic stepEn;
    logic parityEn;
    logic paletteSnoop;
    logic mwiEn;
    logic specialEn;
    logic masterEn;
    logic memEn;
    logic ioEn;
  } pch_cmd_t;

  localparam pch_cmd_t CMD_RST = '0;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  byteEn;
    logic [31:0] wdata;
  } pch_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } pch_cfg_rsp_t;

  typedef struct packed {
    logic        valid;
    logic        isIo;
    logic [31:0] addr;
  } pch_space_t;

  typedef struct packed {
    logic parityErr;
    logic addrParityErr;
    logic targetAbort;
  } pch_evt_t;

endpackage
